// *** rtl/ast_pkg.sv ***
// Package: register map, field positions, reset values and timing counts
package ast_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] TXCTL_OFF  = 8'h00; // transmit_status_control_reg
    localparam logic [7:0] RXCTL_OFF  = 8'h04; // receive_status_control_reg
    localparam logic [7:0] TXHOLD_OFF = 8'h08; // transmit_holding_register
    localparam logic [7:0] RXDATA_OFF = 8'h0C; // receive_data_register
    localparam logic [7:0] BAUD_OFF   = 8'h10; // baud_divisor_register
    localparam logic [7:0] INTCTL_OFF = 8'h14; // interrupt_control_reg
    localparam logic [7:0] PIE_OFF    = 8'h18; // peripheral_irq_enable_reg
    localparam logic [7:0] PIR_OFF    = 8'h1C; // peripheral_irq_flag_reg
    // ==========================================================
    // Transmit control field positions
    localparam int TX_NINTH_BIT  = 0;
    localparam int TX_EMPTY_BIT  = 1;
    localparam int TX_HSPEED_BIT = 2;
    localparam int TX_SYNC_BIT   = 4;
    localparam int TX_EN_BIT     = 5;
    localparam int TX_NINE_BIT   = 6;
    // Receive control field positions
    localparam int RX_NINTH_BIT  = 0;
    localparam int RX_OVR_BIT    = 1;
    localparam int RX_FRM_BIT    = 2;
    localparam int RX_ADDR_BIT   = 3;
    localparam int RX_CONT_BIT   = 4;
    localparam int RX_NINE_BIT   = 6;
    localparam int RX_PORT_BIT   = 7;
    // Interrupt control / enable / flag positions
    localparam int GLOBAL_IE_BIT = 7;
    localparam int PERIPH_IE_BIT = 6;
    localparam int RXI_BIT       = 5;
    localparam int TXI_BIT       = 4;
    // ==========================================================
    // Reset values
    localparam logic [7:0] TXCTL_RST = 8'h02;
    localparam logic [7:0] RXCTL_RST = 8'h00;
    localparam logic [7:0] BAUD_RST  = 8'h00;
    // Baud tick: 16 ticks per bit in low speed, 4 in high speed
    localparam logic [4:0] OVS_LOW   = 5'h10;
    localparam logic [4:0] OVS_HIGH  = 5'h04;
    localparam int         FRAME_W   = 9;
    localparam logic [1:0] AXI_OKAY  = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// *** rtl/ast_if.sv ***
// Interface: shared baud tick and line configuration between modules
`timescale 1ns/1ps
interface ast_if;
    logic       tick;
    logic       high_speed;
    logic       active;
    logic [7:0] divisor;
    modport src (output tick, input high_speed, active, divisor);
    modport snk (input tick, high_speed, active);
endinterface

// *** rtl/ast_baud.sv ***
// Baud tick divider: one-cycle tick every divisor+1 core clocks
`timescale 1ns/1ps
module ast_baud (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Tick link
    ast_if.src        lnk
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!lnk.active) begin
            cnt_d = 8'h00;
        end else if (cnt_q >= lnk.divisor) begin
            cnt_d  = 8'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
    assign lnk.tick = tick_q;
endmodule

// *** rtl/ast_rx.sv ***
// Receive deserialiser: start detect, mid-bit sampling, frame output
`timescale 1ns/1ps
module ast_rx (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Tick link
    ast_if.snk              lnk,
    // Line and control
    input  wire logic       rx_sync,
    input  wire logic       enable,
    input  wire logic       nine,
    // Completed character
    output logic            done,
    output logic [8:0]      data,
    output logic            frame_err
);
    typedef enum logic [1:0] {IDLE, START, BITS, STOP} ast_rx_st_t;
    ast_rx_st_t st_q, st_d;
    logic [4:0] ph_q, ph_d;
    logic [3:0] n_q, n_d;
    logic [8:0] sh_q, sh_d;
    logic       done_d, done_q, fe_d, fe_q;
    logic [4:0] ovs;
    logic [4:0] half;

    assign ovs  = lnk.high_speed ? ast_pkg::OVS_HIGH : ast_pkg::OVS_LOW;
    assign half = {1'b0, ovs[4:1]};

    // Start bit low, LSB first, then one stop bit (see R22)
    always_comb begin
        st_d = st_q; ph_d = ph_q; n_d = n_q; sh_d = sh_q;
        done_d = 1'b0; fe_d = fe_q;
        if (!enable) begin
            st_d = IDLE;
        end else if (lnk.tick) begin
            ph_d = ph_q + 5'h01;
            case (st_q)
                IDLE: begin
                    ph_d = 5'h00;
                    if (!rx_sync) st_d = START;
                end
                START: if (ph_q == half - 5'h01) begin
                    ph_d = 5'h00;
                    n_d  = 4'h0;
                    st_d = rx_sync ? IDLE : BITS;
                end
                BITS: if (ph_q == ovs - 5'h01) begin
                    ph_d = 5'h00;
                    sh_d = nine ? {rx_sync, sh_q[8:1]}
                                : {1'b0, rx_sync, sh_q[7:1]};
                    n_d  = n_q + 4'h1;
                    if (n_q == (nine ? 4'h8 : 4'h7)) st_d = STOP;
                end
                STOP: if (ph_q == ovs - 5'h01) begin
                    st_d   = IDLE;
                    done_d = 1'b1;
                    fe_d   = !rx_sync;
                end
                default: st_d = IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= IDLE; ph_q <= 5'h00; n_q <= 4'h0; sh_q <= 9'h000;
            done_q <= 1'b0; fe_q <= 1'b0;
        end else begin
            st_q <= st_d; ph_q <= ph_d; n_q <= n_d; sh_q <= sh_d;
            done_q <= done_d; fe_q <= fe_d;
        end
    end
    assign done      = done_q;
    assign data      = sh_q;
    assign frame_err = fe_q;
endmodule

// *** rtl/ast_uart.sv ***
// Top: AXI4-Lite register file, transmitter, receive buffer and overrun
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Overview of operation
// R1: shift-empty flag set when shifter idle, clears on load until done
// R2: shift-empty flag is read-only, no interrupt; shifter not mapped
// R3: nine-bit enable shifts nine data bits, ninth from tx ninth bit
// R4: software writes ninth bit before low byte
// R5: holding write moves all nine bits into the shifter
// R6: enabling transmitter sets transmit flag
// R7: transmit flag with all enables raises interrupt at once
// R8: holding write starts transmission when port and transmitter enabled
// R9: software programs divisor and high-speed select first
// R10: asynchronous only when sync clear and port enabled
// R11: receiver accepts characters only with continuous receive set
// R12: receive flag sets on buffer load; interrupt if enabled
// R13: status shows errors and ninth bit; data shows low byte
// R14: clearing continuous receive clears overrun and restarts receiver
// R15: address detect buffers only characters with ninth bit set
// R16: ninth bit reads set in address detect mode
// R17: address detect cleared, every character is buffered
// R18: transmitted ninth bit set marks an address character
// R19: third word before read sets overrun on completion
// R20: on overrun two characters kept, no more accepted
// R21: software reads ninth bit before data register
// R22: one low start, data LSB first, one high stop
module ast_uart (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial line
    input  wire logic        rx_pin,
    output logic             tx_pin,
    // Interrupt request
    output logic             irq
);
    // ==========================================================
    // State
    logic [7:0] txc_q, txc_d, rxc_q, rxc_d, brg_q, brg_d;
    logic [7:0] intc_q, intc_d, pie_q, pie_d, hold_q, hold_d;
    logic       hold9_q, hold9_d, full_q, full_d, txflag_q, txflag_d;
    logic [10:0] tshift_q, tshift_d;
    logic [3:0] tcnt_q, tcnt_d;
    logic [4:0] tph_q, tph_d;
    logic [8:0] fifo_q [2], fifo_d [2];
    logic       fe_q [2], fe_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic       ovr_q, ovr_d;
    logic       rx_m_q, rx_s_q;
    logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic       rx_done, rx_fe, wr_go, rd_go, async_on, tx_on, ld;
    logic [8:0] rx_data;
    logic [4:0] ovs;
    ast_if lnk ();

    // ==========================================================
    // Submodules; rx pin passes two flops first
    assign async_on = rxc_q[ast_pkg::RX_PORT_BIT]
                    && !txc_q[ast_pkg::TX_SYNC_BIT];          // see R10
    assign tx_on    = async_on && txc_q[ast_pkg::TX_EN_BIT];
    assign lnk.high_speed = txc_q[ast_pkg::TX_HSPEED_BIT];
    assign lnk.active     = async_on;
    assign lnk.divisor    = brg_q;
    assign ovs = lnk.high_speed ? ast_pkg::OVS_HIGH : ast_pkg::OVS_LOW;

    ast_baud u_baud (.core_clk(core_clk), .reset_n(reset_n), .lnk(lnk));
    ast_rx u_rx (
        .core_clk (core_clk), .reset_n (reset_n), .lnk (lnk),
        .rx_sync  (rx_s_q),
        .enable   (async_on && rxc_q[ast_pkg::RX_CONT_BIT]), // see R11
        .nine     (rxc_q[ast_pkg::RX_NINE_BIT]),
        .done     (rx_done), .data (rx_data), .frame_err (rx_fe)
    );

    // ==========================================================
    // Bus channel capture
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready  = !w_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign wr_go = aw_q && w_q && !bv_q;
    assign rd_go = s_axi_arvalid && !rv_q;

    // ==========================================================
    // Next state
    always_comb begin
        txc_d = txc_q; rxc_d = rxc_q; brg_d = brg_q; intc_d = intc_q;
        pie_d = pie_q; hold_d = hold_q; hold9_d = hold9_q;
        full_d = full_q; txflag_d = txflag_q; tshift_d = tshift_q;
        tcnt_d = tcnt_q; tph_d = tph_q; fifo_d = fifo_q; fe_d = fe_q;
        cnt_d = cnt_q; ovr_d = ovr_q;
        aw_d = aw_q; w_d = w_q; bv_d = bv_q; rv_d = rv_q;
        awa_d = awa_q; wd_d = wd_q; rd_d = rd_q; br_d = br_q; rr_d = rr_q;
        ld = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1; awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1; wd_d = s_axi_wdata;
            if (!s_axi_wstrb[0]) wd_d[7:0] = 8'h00;
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (rv_q && s_axi_rready) rv_d = 1'b0;
        // Register writes; byte lane 0 only, clear lane 0 strobe writes zero
        if (wr_go) begin
            aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1; br_d = ast_pkg::AXI_OKAY;
            case (awa_q)
                ast_pkg::TXCTL_OFF: begin
                    // Shift-empty bit kept, not writable (see R2)
                    txc_d = {wd_q[7:2], txc_q[ast_pkg::TX_EMPTY_BIT],
                             wd_q[0]};
                end
                ast_pkg::RXCTL_OFF: begin
                    rxc_d = {wd_q[7:3], rxc_q[2:0]};
                    if (!wd_q[ast_pkg::RX_CONT_BIT]) ovr_d = 1'b0; // see R14
                end
                ast_pkg::TXHOLD_OFF: if (tx_on) begin         // see R8
                    // Ninth bit captured now, written earlier (see R4)
                    hold_d = wd_q[7:0];
                    hold9_d = txc_q[ast_pkg::TX_NINTH_BIT];    // see R5
                    full_d = 1'b1; txflag_d = 1'b0;
                end
                ast_pkg::BAUD_OFF:   brg_d = wd_q[7:0];       // see R9
                ast_pkg::INTCTL_OFF: intc_d = wd_q[7:0];
                ast_pkg::PIE_OFF:    pie_d = wd_q[7:0];
                ast_pkg::PIR_OFF:    ;
                ast_pkg::RXDATA_OFF: ;
                default: br_d = ast_pkg::AXI_SLVERR;
            endcase
        end
        // Transmitter: idle marks the shift-empty flag (see R1)
        if (!tx_on) begin
            tcnt_d = 4'h0; full_d = 1'b0;
            txc_d[ast_pkg::TX_EMPTY_BIT] = 1'b1;
            // Holding is empty, so the flag follows the enable (see R6)
            txflag_d = txc_d[ast_pkg::TX_EN_BIT]
                     && rxc_d[ast_pkg::RX_PORT_BIT]
                     && !txc_d[ast_pkg::TX_SYNC_BIT];
        end else if (tcnt_q == 4'h0) begin
            if (full_q) begin
                // Frame: start 0, data LSB first, ninth if enabled, stop 1
                tshift_d = txc_q[ast_pkg::TX_NINE_BIT]
                      ? {1'b1, hold9_q, hold_q, 1'b0}         // see R3
                      : {2'b11, hold_q, 1'b0};                // see R18
                tcnt_d = txc_q[ast_pkg::TX_NINE_BIT] ? 4'hB : 4'hA;
                tph_d  = 5'h00;
                full_d = 1'b0; txflag_d = 1'b1;
                txc_d[ast_pkg::TX_EMPTY_BIT] = 1'b0;          // see R1
            end
        end else if (lnk.tick) begin
            tph_d = tph_q + 5'h01;
            if (tph_q == ovs - 5'h01) begin
                tph_d = 5'h00;
                tshift_d = {1'b1, tshift_q[10:1]};            // see R22
                tcnt_d = tcnt_q - 4'h1;
                if (tcnt_q == 4'h1 && !full_d)
                    txc_d[ast_pkg::TX_EMPTY_BIT] = 1'b1;      // see R1
            end
        end
        // Receive data read pops the buffer (see R21)
        if (rd_go) begin
            rv_d = 1'b1; rr_d = ast_pkg::AXI_OKAY; rd_d = 32'h0000_0000;
            case (s_axi_araddr)
                ast_pkg::TXCTL_OFF:  rd_d[7:0] = txc_q;
                ast_pkg::RXCTL_OFF: begin                     // see R13
                    rd_d[7:0] = {rxc_q[7:3], fe_q[0], ovr_q,
                                 rxc_q[ast_pkg::RX_NINE_BIT] && fifo_q[0][8]};
                    if (rxc_q[ast_pkg::RX_ADDR_BIT]
                        && rxc_q[ast_pkg::RX_NINE_BIT])
                        rd_d[ast_pkg::RX_NINTH_BIT] = 1'b1;   // see R16
                end
                ast_pkg::RXDATA_OFF: begin
                    rd_d[7:0] = fifo_q[0][7:0];               // see R13
                    if (cnt_q != 2'h0) begin
                        fifo_d[0] = fifo_q[1]; fe_d[0] = fe_q[1];
                        cnt_d = cnt_q - 2'h1;
                    end
                end
                ast_pkg::BAUD_OFF:   rd_d[7:0] = brg_q;
                ast_pkg::INTCTL_OFF: rd_d[7:0] = intc_q;
                ast_pkg::PIE_OFF:    rd_d[7:0] = pie_q;
                ast_pkg::PIR_OFF: begin
                    rd_d[ast_pkg::RXI_BIT] = cnt_q != 2'h0;
                    rd_d[ast_pkg::TXI_BIT] = txflag_q;
                end
                ast_pkg::TXHOLD_OFF: ;
                default: rr_d = ast_pkg::AXI_SLVERR;
            endcase
        end
        // Completed character; a same-cycle pop is seen first
        if (rx_done && !ovr_q) begin                          // see R20
            if (!(rxc_q[ast_pkg::RX_ADDR_BIT] && rxc_q[ast_pkg::RX_NINE_BIT])
                || rx_data[8]) begin                          // see R15 R17
                if (cnt_d == 2'h2) begin
                    ovr_d = 1'b1;                             // see R19
                end else begin
                    fifo_d[cnt_d[0]] = rx_data;               // see R12
                    fe_d[cnt_d[0]] = rx_fe;
                    cnt_d = cnt_d + 2'h1;
                end
            end
        end
        if (!rxc_q[ast_pkg::RX_CONT_BIT]) ovr_d = 1'b0;       // see R14
    end

    // Level interrupt from the two enable levels (see R7 R12)
    assign irq = intc_q[ast_pkg::GLOBAL_IE_BIT]
               && intc_q[ast_pkg::PERIPH_IE_BIT]
               && ((pie_q[ast_pkg::TXI_BIT] && txflag_q)
                   || (pie_q[ast_pkg::RXI_BIT] && cnt_q != 2'h0));

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txc_q <= ast_pkg::TXCTL_RST; rxc_q <= ast_pkg::RXCTL_RST;
            brg_q <= ast_pkg::BAUD_RST; intc_q <= 8'h00; pie_q <= 8'h00;
            hold_q <= 8'h00; hold9_q <= 1'b0; full_q <= 1'b0;
            txflag_q <= 1'b0; tshift_q <= 11'h7FF; tcnt_q <= 4'h0;
            tph_q <= 5'h00; fifo_q[0] <= 9'h000; fifo_q[1] <= 9'h000;
            fe_q[0] <= 1'b0; fe_q[1] <= 1'b0; cnt_q <= 2'h0;
            ovr_q <= 1'b0; rx_m_q <= 1'b1; rx_s_q <= 1'b1;
            aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
            awa_q <= 8'h00; wd_q <= 32'h0000_0000; rd_q <= 32'h0000_0000;
            br_q <= 2'h0; rr_q <= 2'h0;
        end else begin
            txc_q <= txc_d; rxc_q <= rxc_d; brg_q <= brg_d;
            intc_q <= intc_d; pie_q <= pie_d; hold_q <= hold_d;
            hold9_q <= hold9_d; full_q <= full_d; txflag_q <= txflag_d;
            tshift_q <= tshift_d; tcnt_q <= tcnt_d; tph_q <= tph_d;
            fifo_q <= fifo_d; fe_q <= fe_d; cnt_q <= cnt_d;
            ovr_q <= ovr_d; rx_m_q <= rx_pin; rx_s_q <= rx_m_q;
            aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
            awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
            br_q <= br_d; rr_q <= rr_d;
        end
    end

    assign tx_pin = (tcnt_q == 4'h0) ? 1'b1 : tshift_q[0];
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp  = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata  = rd_q;
    assign s_axi_rresp  = rr_q;

    // ==========================================================
    // Checks
    sequence s_load;
        tx_on && tcnt_q == 4'h0 && full_q;
    endsequence
    AST_EMPTY_CLR: assert property ( // see R1
        @(posedge core_clk) disable iff (!reset_n)
        s_load |=> !txc_q[ast_pkg::TX_EMPTY_BIT])
        else $error("shift empty not cleared on load");
    AST_EMPTY_BUSY: assert property ( // see R1
        @(posedge core_clk) disable iff (!reset_n)
        (tcnt_q > 4'h1) |-> !txc_q[ast_pkg::TX_EMPTY_BIT])
        else $error("shift empty set while shifting");
    AST_TRANSMIT_IRQ_FLAG_EN: assert property ( // see R6
        @(posedge core_clk) disable iff (!reset_n)
        (!tx_on ##1 tx_on && !full_q && tcnt_q == 4'h0) |=> txflag_q)
        else $error("transmit flag not set on enable");
    AST_IRQ_TX: assert property ( // see R7
        @(posedge core_clk) disable iff (!reset_n)
        (txflag_q && pie_q[ast_pkg::TXI_BIT]
         && intc_q[ast_pkg::GLOBAL_IE_BIT]
         && intc_q[ast_pkg::PERIPH_IE_BIT]) |-> irq)
        else $error("transmit interrupt missing");
    AST_START_LOW: assert property ( // see R22
        @(posedge core_clk) disable iff (!reset_n)
        s_load |=> !tx_pin)
        else $error("start bit not low");
    AST_IDLE_HIGH: assert property ( // see R22
        @(posedge core_clk) disable iff (!reset_n)
        !tx_on |=> tx_pin)
        else $error("idle line not high");
    AST_RX_GATE: assert property ( // see R11
        @(posedge core_clk) disable iff (!reset_n)
        !rxc_q[ast_pkg::RX_CONT_BIT]
        |=> $stable(cnt_q) || cnt_q < $past(cnt_q))
        else $error("character accepted while disabled");
    AST_OVR_SET: assert property ( // see R19
        @(posedge core_clk) disable iff (!reset_n)
        (rx_done && cnt_q == 2'h2 && !rd_go && rxc_q[ast_pkg::RX_CONT_BIT]
         && !rxc_q[ast_pkg::RX_ADDR_BIT]) |=> ovr_q)
        else $error("overrun not set on third word");
    AST_OVR_HOLD: assert property ( // see R20
        @(posedge core_clk) disable iff (!reset_n)
        (ovr_q && !rd_go) |=> $stable(fifo_q[0]) && $stable(fifo_q[1]))
        else $error("buffer changed during overrun");
    AST_OVR_CLR: assert property ( // see R14
        @(posedge core_clk) disable iff (!reset_n)
        !rxc_q[ast_pkg::RX_CONT_BIT] |=> !ovr_q)
        else $error("overrun not cleared");
endmodule

// *** tb/ast_node.sv ***
// Remote serial node model: sends and captures asynchronous frames
`timescale 1ns/1ps
module ast_node #(
    parameter int BIT = 8
) (
    // Clock
    input  wire logic   clk,
    // Line
    input  wire logic   line_in,
    output logic        line_out,
    // Capture
    input  wire logic   nine,
    output logic [8:0]  got,
    output int          frames
);
    int i;
    // Start low, data LSB first, stop high; line idles high
    task automatic send(input logic [8:0] v, input logic n);
        logic [10:0] f;
        f = n ? {1'b1, v, 1'b0} : {2'b11, v[7:0], 1'b0};
        for (int k = 0; k < 11; k++) begin
            @(posedge clk);
            line_out <= f[k];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask
    // Samples mid-bit; a frame counts only with a high stop bit
    initial begin
        line_out = 1'b1;
        got = '0;
        frames = 0;
        forever begin
            @(negedge line_in);
            repeat (BIT / 2) @(posedge clk);
            for (i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (BIT) @(posedge clk);
                got[i] = line_in;
            end
            if (!nine) got[8] = 1'b0;
            repeat (BIT) @(posedge clk);
            if (line_in === 1'b1) frames++;
        end
    end
endmodule

// *** tb/ast_uart_test.sv ***
// Testbench: register sequences over AXI4-Lite against a serial node
`timescale 1ns/1ps
module ast_uart_test;
    localparam int BIT = 8;
    localparam logic [7:0] TX = ast_pkg::TXCTL_OFF, RX = ast_pkg::RXCTL_OFF,
        TH = ast_pkg::TXHOLD_OFF, RD = ast_pkg::RXDATA_OFF,
        PE = ast_pkg::PIE_OFF, BD = ast_pkg::BAUD_OFF,
        IC = ast_pkg::INTCTL_OFF, PR = ast_pkg::PIR_OFF;
    logic        core_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_pin, tx_pin;
    logic        irq, nine;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [8:0]  got;
    int          frames, num_errors, checked;
    // ==========================================================
    // Instances
    ast_uart i_ast_uart (.*);
    ast_node #(.BIT(BIT)) i_ast_node (.clk(core_clk), .line_in(tx_pin),
        .line_out(rx_pin), .nine(nine), .got(got), .frames(frames));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ==========================================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("reg %h", a), {24'h000000, e}, d);
        chk("rresp", {30'h0, ast_pkg::AXI_OKAY}, {30'h0, r});
    endtask
    // Frame plus margin for synchroniser and stop sampling
    task automatic ch(input logic [8:0] v, input logic n);
        i_ast_node.send(v, n);
        repeat (BIT) @(posedge core_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard: whole sequence needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        complete_run;
    end
    // ==========================================================
    // Tests
    initial begin
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, nine, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        {num_errors, checked} = '0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rc(TX, 8'h02);
        rd(8'h20);
        chk("unmapped", {30'h0, ast_pkg::AXI_SLVERR}, {30'h0, r});
        wr(BD, 8'h01);
        wr(TX, 8'h24);
        wr(RX, 8'h80);
        rc(TX, 8'h26);
        rc(PR, 8'h10);
        wr(IC, 8'hC0);
        wr(PE, 8'h10);
        chk("irq", 32'h1, {31'h0, irq});
        wr(PE, 8'h00);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test setup done");
        nine = 1'b1;
        wr(TX, 8'h65);
        wr(TH, 8'hA5);
        rc(TX, 8'h65);
        wait (frames == 1);
        chk("frame", 32'h1A5, {23'h0, got});
        repeat (BIT) @(posedge core_clk);
        rc(TX, 8'h67);
        $display("test transmit done");
        ch(9'h03C, 1'b0);
        rc(PR, 8'h10);
        wr(PE, 8'h20);
        wr(RX, 8'h90);
        ch(9'h03C, 1'b0);
        rc(PR, 8'h30);
        chk("irq", 32'h1, {31'h0, irq});
        rc(RX, 8'h90);
        rc(RD, 8'h3C);
        ch(9'h011, 1'b0);
        ch(9'h022, 1'b0);
        ch(9'h033, 1'b0);
        rc(RX, 8'h92);
        rc(RD, 8'h11);
        rc(RD, 8'h22);
        rc(PR, 8'h10);
        wr(RX, 8'h80);
        rc(RX, 8'h80);
        $display("test receive done");
        wr(RX, 8'hD8);
        ch(9'h055, 1'b1);
        rc(PR, 8'h10);
        ch(9'h1AA, 1'b1);
        rc(RX, 8'hD9);
        rc(RD, 8'hAA);
        wr(RX, 8'hD0);
        ch(9'h033, 1'b1);
        rc(RX, 8'hD0);
        rc(RD, 8'h33);
        $display("test address done");
        complete_run;
    end
endmodule
